//--- pwc3_map.vh
// Address map, field positions and timing constants of the bundle configuration word three bank.
`ifndef PWC3_MAP_VH
`define PWC3_MAP_VH

// Register window: one 32-bit word per bundle, at a stride of four bytes.
`define PWC3_CFG_BASE        12'h0300
`define PWC3_CFG_LAST        12'h03FC
`define PWC3_STAT_ADDR       12'h0500
`define PWC3_BUNDLES         64

// Field positions inside the configuration word.
`define PWC3_F_RSV_HI        31
`define PWC3_F_DV_HI         30
`define PWC3_F_DV_WIDE_LO    26
`define PWC3_F_DV_LO         16
`define PWC3_F_SIG_SRC       15
`define PWC3_F_REORDER       14
`define PWC3_F_RSV_MID       13
`define PWC3_F_OAM_CHK       12
`define PWC3_F_DROP_ALL      11
`define PWC3_F_DEST_CPU      10
`define PWC3_F_LBL_HI        9
`define PWC3_F_LBL_LO        8
`define PWC3_F_PORT_HI       7
`define PWC3_F_PORT_LO       4
`define PWC3_F_VLAN_HI       3
`define PWC3_F_VLAN_LO       2
`define PWC3_F_BID_VALID     1
`define PWC3_F_RSV_LO        0

// Reset value of every word; the hardware defines none, so zero is used.
`define PWC3_CFG_RESET       32'h0000_0000

// Interface types of a bundle.
`define PWC3_IF_FRAMED       2'h0
`define PWC3_IF_UNFRAMED     2'h1
`define PWC3_IF_SERIAL       2'h2
`define PWC3_IF_HIGH_SPEED   2'h3

// Resolution of one delay variation window unit.
`define PWC3_CLK_PERIOD_PS   25000
`define PWC3_FRAMED_UNIT_PS  500000000
`define PWC3_FRAMED_UNIT_CYC (`PWC3_FRAMED_UNIT_PS / `PWC3_CLK_PERIOD_PS)
`define PWC3_LOW_UNIT_BITS   16'h0020
`define PWC3_HIGH_UNIT_BITS  16'h0080

// Software limits on the window, reported back as warnings.
`define PWC3_DV_MIN          15'h0003
`define PWC3_DV_T1_LIMIT     15'h0300

`endif

//--- pwc3_bank.v
// Per-bundle configuration word three: APB register bank, field decode and receive decisions.
`timescale 1ns/10ps
`include "pwc3_map.vh"

// Behaviour
// [R1] Window is bits 30..16; bits 30..26 only count for unframed bundles.
// [R2] Window unit: 0.5 ms framed, 32 bit periods low speed, 128 high speed.
// [R3] Software keeps the window at 3 or more for every interface type.
// [R4] Software keeps the window below 0x300 for T1 SF or ESF bundles.
// [R5] Bit 15 picks signaling source: jitter buffer when 0, software tables when 1.
// [R6] Bit 14 enables resequencing of received packets; otherwise order is kept.
// [R7] Bit 12 set means the control word OAM flag is examined, else ignored.
// [R8] Bit 11 drops all received packets; bit 10 sends passed ones to CPU.
// [R9] MPLS: codes 01, 10, 11 of bits 9..8 give one to three labels.
// [R10] L2TPv3: codes 00, 01, 10 give zero to two cookies; 11 reserved.
// [R11] Bits 7..4 assign the TDM port, 0000 first port, 0111 eighth port.
// [R12] Bits 3..2 give zero to two VLAN tags for the MAC transmitter only.
// [R13] Invalid identifier plus classifier miss follows the classifier discard switches.
// [R14] Software writes zero to reserved bits 31, 13 and 0.
// [R15] One word per bundle, bundles 0 to 63, four bytes apart.
// [R16] No reset value exists, so software programs the word before service.
module pwc3_bank #(
    parameter BUNDLES          = `PWC3_BUNDLES,
    parameter FRAMED_UNIT_CYC  = `PWC3_FRAMED_UNIT_CYC
) (
    // Clock, reset and clock enable.
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        clk_en,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Transmit and timing query for one bundle.
    input  wire [5:0]  qry_bundle,
    input  wire [1:0]  qry_iface_type,
    input  wire        qry_t1_sf_esf,
    input  wire        qry_encap_mpls,
    output reg  [14:0] rx_delay_variation_window_q,
    output reg  [15:0] dv_unit_q,
    output reg         dv_unit_is_clk_q,
    output reg  [1:0]  tx_label_cookie_count_q,
    output reg         tx_label_code_bad_q,
    output reg  [1:0]  tx_vlan_tag_count_q,
    output reg         tx_vlan_code_bad_q,
    output reg  [3:0]  tdm_port_q,
    output reg         tdm_port_bad_q,
    output reg         sig_from_sw_q,
    // Receive packet decision.
    input  wire        pkt_valid,
    input  wire [5:0]  pkt_bundle,
    input  wire        pkt_oam_flag,
    input  wire        pkt_cls_hit,
    input  wire        classifier_config_three_discard,
    output reg         pkt_done_q,
    output reg         pkt_drop_q,
    output reg         pkt_to_cpu_q,
    output reg         pkt_is_oam_q,
    output reg         pkt_reorder_q
);

    // Storage for every bundle word, indexed by bundle number.
    reg  [31:0] cfg_q [0:BUNDLES-1];
    reg  [31:0] stat_q;
    reg  [31:0] stat_d;
    integer     i;

    // Address decode of an APB request.
    wire        sel_cfg   = (paddr >= `PWC3_CFG_BASE) && (paddr <= `PWC3_CFG_LAST); // [R15]
    wire        sel_stat  = (paddr == `PWC3_STAT_ADDR);
    wire        aligned   = (paddr[1:0] == 2'b00);
    wire [5:0]  wr_idx    = paddr[7:2];
    wire        setup     = psel && !penable;
    wire        hit       = aligned && (sel_cfg || sel_stat);

    // Label or cookie count for the encapsulation in use; flags reserved codes.
    function [2:0] lbl_decode;
        input [1:0] code;
        input       mpls;
        begin
            if (mpls) begin
                lbl_decode = {(code == 2'b00), code};                 // [R9]
            end else begin
                lbl_decode = {(code == 2'b11), code};                 // [R10]
            end
        end
    endfunction

    // Effective delay window: upper five bits vanish unless unframed.
    function [14:0] dv_decode;
        input [31:0] word;
        input [1:0]  itype;
        begin
            dv_decode = word[`PWC3_F_DV_HI:`PWC3_F_DV_LO];
            if (itype != `PWC3_IF_UNFRAMED) begin
                dv_decode[14:10] = 5'h00;                             // [R1]
            end
        end
    endfunction

    wire [31:0] qry_word = cfg_q[qry_bundle];
    wire [31:0] pkt_word = cfg_q[pkt_bundle];
    wire [14:0] qry_dv   = dv_decode(qry_word, qry_iface_type);
    wire [2:0]  qry_lbl  = lbl_decode(qry_word[`PWC3_F_LBL_HI:`PWC3_F_LBL_LO], qry_encap_mpls);
    wire [1:0]  qry_vlan = qry_word[`PWC3_F_VLAN_HI:`PWC3_F_VLAN_LO];
    wire [3:0]  qry_port = qry_word[`PWC3_F_PORT_HI:`PWC3_F_PORT_LO];

    // Window limits that software must keep; violations only show in status.
    wire        dv_low   = (qry_dv < `PWC3_DV_MIN);                   // [R3]
    wire        dv_t1hi  = qry_t1_sf_esf && (qry_dv >= `PWC3_DV_T1_LIMIT); // [R4]
    wire        rsv_set  = qry_word[`PWC3_F_RSV_HI] | qry_word[`PWC3_F_RSV_MID]
                         | qry_word[`PWC3_F_RSV_LO];                  // [R14]

    // Status word mirrors the checks on the bundle under query.
    always @* begin
        stat_d        = 32'h0000_0000;
        stat_d[0]     = dv_low;
        stat_d[1]     = dv_t1hi;
        stat_d[2]     = rsv_set;
        stat_d[3]     = qry_lbl[2];
        stat_d[4]     = (qry_vlan == 2'b11);
        stat_d[5]     = qry_port[3];
        stat_d[13:8]  = qry_bundle;
    end

    // Register writes; the words have no defined reset, zero keeps simulation clean.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < BUNDLES; i = i + 1) begin
                cfg_q[i] <= `PWC3_CFG_RESET;                          // [R16]
            end
        end else if (clk_en && psel && penable && pwrite && aligned && sel_cfg) begin
            cfg_q[wr_idx] <= pwdata;                                  // [R15]
        end
    end

    // APB answer: data and response are prepared in setup, valid in the first access cycle.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite && hit) begin
                prdata <= sel_stat ? stat_q : cfg_q[wr_idx];
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Query decode, one cycle after the bundle select.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q                      <= 32'h0000_0000;
            rx_delay_variation_window_q <= 15'h0000;
            dv_unit_q                   <= 16'h0000;
            dv_unit_is_clk_q            <= 1'b0;
            tx_label_cookie_count_q     <= 2'b00;
            tx_label_code_bad_q         <= 1'b0;
            tx_vlan_tag_count_q         <= 2'b00;
            tx_vlan_code_bad_q          <= 1'b0;
            tdm_port_q                  <= 4'h0;
            tdm_port_bad_q              <= 1'b0;
            sig_from_sw_q               <= 1'b0;
        end else if (clk_en) begin
            stat_q                      <= stat_d;
            rx_delay_variation_window_q <= qry_dv;                    // [R1]
            // Framed units are timed in clocks; line rates are unknown here, so bit periods.
            case (qry_iface_type)
                `PWC3_IF_FRAMED: begin
                    dv_unit_q        <= FRAMED_UNIT_CYC[15:0];        // [R2]
                    dv_unit_is_clk_q <= 1'b1;
                end
                `PWC3_IF_HIGH_SPEED: begin
                    dv_unit_q        <= `PWC3_HIGH_UNIT_BITS;         // [R2]
                    dv_unit_is_clk_q <= 1'b0;
                end
                default: begin
                    dv_unit_q        <= `PWC3_LOW_UNIT_BITS;          // [R2]
                    dv_unit_is_clk_q <= 1'b0;
                end
            endcase
            // MPLS code n means n labels, L2TPv3 code n means n cookies.
            tx_label_cookie_count_q     <= qry_lbl[1:0];              // [R9] [R10]
            tx_label_code_bad_q         <= qry_lbl[2];
            // Tags go to the MAC transmitter; receive ignores this field.
            tx_vlan_tag_count_q         <= qry_vlan;                  // [R12]
            tx_vlan_code_bad_q          <= (qry_vlan == 2'b11);       // [R12]
            tdm_port_q                  <= qry_port;                  // [R11]
            tdm_port_bad_q              <= qry_port[3];               // [R11]
            sig_from_sw_q               <= qry_word[`PWC3_F_SIG_SRC]; // [R5]
        end
    end

    // Receive decision, one cycle after the packet strobe.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pkt_done_q    <= 1'b0;
            pkt_drop_q    <= 1'b0;
            pkt_to_cpu_q  <= 1'b0;
            pkt_is_oam_q  <= 1'b0;
            pkt_reorder_q <= 1'b0;
        end else if (clk_en) begin
            pkt_done_q <= pkt_valid;
            if (pkt_valid) begin
                // A classifier miss on an invalid identifier obeys the discard switch.
                if (!pkt_cls_hit && !pkt_word[`PWC3_F_BID_VALID]) begin
                    pkt_drop_q <= classifier_config_three_discard;    // [R13]
                end else begin
                    pkt_drop_q <= pkt_word[`PWC3_F_DROP_ALL];         // [R8]
                end
                pkt_to_cpu_q  <= pkt_word[`PWC3_F_DEST_CPU];          // [R8]
                pkt_is_oam_q  <= pkt_word[`PWC3_F_OAM_CHK] && pkt_oam_flag; // [R7]
                pkt_reorder_q <= pkt_word[`PWC3_F_REORDER];           // [R6]
            end
        end
    end

endmodule // pwc3_bank

//--- pwc3_chk.sv
// Port checks for the configuration word three bank.
`timescale 1ns/10ps
module pwc3_chk #(
    parameter FRAMED_UNIT_CYC = 20000
) (
    // Clock and reset.
    input wire        mclk,
    input wire        arst_n,
    input wire        clk_en,
    // APB.
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    // Packet path.
    input wire        pkt_valid,
    input wire        pkt_oam_flag,
    input wire        pkt_done_q,
    input wire        pkt_is_oam_q,
    // Query path.
    input wire [1:0]  qry_iface_type,
    input wire        qry_encap_mpls,
    input wire [14:0] rx_delay_variation_window_q,
    input wire [15:0] dv_unit_q,
    input wire        dv_unit_is_clk_q,
    input wire [1:0]  tx_label_cookie_count_q,
    input wire        tx_label_code_bad_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // A setup cycle taken while the bank runs.
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    // Zero wait states, and pready never stands two cycles.
    a_ready_next: assert property (s_setup |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("pready long");
    // Only the 64 aligned words and the status word are mapped.
    a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 ||
        !((paddr >= 12'h0300 && paddr <= 12'h03fc) || paddr == 12'h0500))) else $error("pslverr");
    a_done_next: assert property (pkt_valid && clk_en |=> pkt_done_q) else $error("no done");
    a_oam_gate: assert property (pkt_valid && clk_en && !pkt_oam_flag |=> !pkt_is_oam_q)
        else $error("oam without flag");
    // The unit follows the interface type given one cycle before; the edge that releases
    // reset is skipped because the registers still held their reset values there.
    a_unit_map: assert property (clk_en && arst_n |=> dv_unit_is_clk_q == ($past(qry_iface_type) == 2'h0)
        && dv_unit_q == ($past(qry_iface_type) == 2'h0 ? 16'(FRAMED_UNIT_CYC) :
        $past(qry_iface_type) == 2'h3 ? 16'h0080 : 16'h0020)) else $error("unit");
    a_window_mask: assert property (clk_en && qry_iface_type != 2'h1 |=>
        rx_delay_variation_window_q[14:10] == 5'h00) else $error("window top bits");
    a_label_bad: assert property (clk_en && arst_n |=> tx_label_code_bad_q == ($past(qry_encap_mpls) ?
        tx_label_cookie_count_q == 2'h0 : tx_label_cookie_count_q == 2'h3)) else $error("label");
endmodule // pwc3_chk

bind pwc3_bank pwc3_chk #(.FRAMED_UNIT_CYC(FRAMED_UNIT_CYC)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
    .pkt_oam_flag(pkt_oam_flag), .pkt_done_q(pkt_done_q), .pkt_is_oam_q(pkt_is_oam_q),
    .qry_iface_type(qry_iface_type), .qry_encap_mpls(qry_encap_mpls),
    .rx_delay_variation_window_q(rx_delay_variation_window_q), .dv_unit_q(dv_unit_q),
    .dv_unit_is_clk_q(dv_unit_is_clk_q), .tx_label_cookie_count_q(tx_label_cookie_count_q),
    .tx_label_code_bad_q(tx_label_code_bad_q)
);

//--- testbench.sv
// Self-checking bench for the configuration word three bank.
`timescale 1ns/10ps
module testbench;
    reg         mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, qm = 0;
    reg         pkt_valid = 0, oam = 0, hit = 0, disc = 0, er, t1 = 0;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd, mem [0:63];
    reg  [5:0]  qb = 0, pb = 0;
    reg  [1:0]  qt = 0;
    wire [31:0] prdata;
    wire [14:0] win;
    wire [15:0] unit;
    wire [3:0]  port;
    wire [1:0]  lc, vc;
    wire        pready, pslverr, isclk, lbad, vbad, pbad, sig, done, drop, cpu, isoam, reord;
    integer     error_cnt = 0, checked = 0, seed = 32'h4e07_004e, i;

    // Framed unit shortened to 20 clocks to keep the run brief.
    pwc3_bank #(.FRAMED_UNIT_CYC(20)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .qry_bundle(qb), .qry_iface_type(qt), .qry_t1_sf_esf(t1),
        .qry_encap_mpls(qm), .rx_delay_variation_window_q(win), .dv_unit_q(unit),
        .dv_unit_is_clk_q(isclk), .tx_label_cookie_count_q(lc), .tx_label_code_bad_q(lbad),
        .tx_vlan_tag_count_q(vc), .tx_vlan_code_bad_q(vbad), .tdm_port_q(port),
        .tdm_port_bad_q(pbad), .sig_from_sw_q(sig), .pkt_valid(pkt_valid), .pkt_bundle(pb),
        .pkt_oam_flag(oam), .pkt_cls_hit(hit), .classifier_config_three_discard(disc),
        .pkt_done_q(done), .pkt_drop_q(drop), .pkt_to_cpu_q(cpu), .pkt_is_oam_q(isoam),
        .pkt_reorder_q(reord)
    );

    // Free-running 40 MHz clock.
    initial forever #12.5 mclk = ~mclk;

    // Query outputs expected for a word, interface type and encapsulation.
    function [43:0] qexp(input [31:0] w, input [1:0] it, input m);
        qexp = {w[30:26] & {5{it == 2'h1}}, w[25:16], it == 2'h0 ? 16'h0014 :
            it == 2'h3 ? 16'h0080 : 16'h0020, it == 2'h0, w[9:8],
            m ? w[9:8] == 2'h0 : w[9:8] == 2'h3, w[3:2], w[3:2] == 2'h3, w[7:4], w[7], w[15]};
    endfunction

    // Packet decision; an unknown identifier on a miss defers to the discard switch.
    function [3:0] pexp(input [31:0] w, input o, input h, input d);
        pexp = {(!h && !w[1]) ? d : w[11], w[10], w[12] & o, w[14]};
    endfunction

    // Status word: window limits, reserved codes and the bundle under query.
    function [31:0] sexp(input [31:0] w, input [1:0] it, input m, input t, input [5:0] b);
        reg [14:0] dv;
        begin
            dv = {w[30:26] & {5{it == 2'h1}}, w[25:16]};
            sexp = {18'h0, b, 2'h0, w[7], w[3:2] == 2'h3, m ? w[9:8] == 2'h0 : w[9:8] == 2'h3,
                w[31] | w[13] | w[0], t && dv >= 15'h0300, dv < 15'h0003};
        end
    endfunction

    task chk(input string n, input [63:0] e, input [63:0] g);
        checked = checked + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        chk("apb wait", 0, n >= 20);
    endtask

    task final_report;
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Main sequence: program, refuse, read back, query, then packets.
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1;
        for (i = 0; i < 64; i = i + 1) begin
            mem[i] = (i == 0) ? 32'h7fff_dffe : (i == 63) ? 0 : $random(seed) & 32'h7fff_dffe;
            apb(1, 12'h0300 + 4 * i, mem[i]);
            chk("write error", 0, er);
        end
        for (i = 0; i < 6; i = i + 1) begin
            apb(i[0], i < 2 ? 12'h02fc : i < 4 ? 12'h0302 : 12'h0400, 32'hffff_ffff);
            chk("refused", 1, er);
            if (!i[0]) chk("refused data", 0, rd);
        end
        for (i = 0; i < 64; i = i + 1) begin
            apb(0, 12'h0300 + 4 * i, 0);
            chk("word", {er, mem[i]}, {1'b0, rd});
        end
        // Status reads with the query inputs held steady through the whole transfer.
        for (i = 0; i < 16; i = i + 1) begin
            qb <= (i < 2) ? 6'd0 : $random(seed);
            qt <= (i < 2) ? 2'h1 : $random(seed);
            qm <= $random(seed);
            t1 <= (i < 2) ? 1'b1 : $random(seed);
            @(posedge mclk);
            apb(0, 12'h0500, 0);
            chk("status", {er, sexp(mem[qb], qt, qm, t1, qb)}, {1'b0, rd});
        end
        t1 <= 0;
        for (i = 0; i < 128; i = i + 1) begin
            qb <= i[5:0];
            qt <= i[1:0];
            qm <= $random(seed);
            @(posedge mclk);
            @(posedge mclk);
            chk("query", qexp(mem[qb], qt, qm), {win, unit, isclk, lc, lbad, vc, vbad, port,
                pbad, sig});
        end
        for (i = 0; i < 200; i = i + 1) begin
            {pb, oam, hit, disc} <= $random(seed);
            pkt_valid <= 1;
            @(posedge mclk);
            pkt_valid <= 0;
            @(posedge mclk);
            chk("packet", {1'b1, pexp(mem[pb], oam, hit, disc)}, {done, drop, cpu, isoam, reord});
        end
        final_report;
    end

    // Watchdog well beyond the roughly 1200 cycles the sequence needs.
    initial begin
        #(25 * 5000);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule // testbench
